// >>> rtl/pcsd_decoder.sv
// Paged memory chip select decoder: combinational selects for a host bus
`timescale 1ns/100ps
module pcsd_decoder (
  // Clock and reset (assertion sampling only)
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // Host bus
  input  wire pcsd_pkg::pcsd_bus_t bus_i,
  // Paging
  input  wire pcsd_pkg::pcsd_page_t page_i,
  input  wire logic                host_expansion_line_i,
  input  wire logic                expansion_mode_i,
  // Selects
  output wire pcsd_pkg::pcsd_sel_t sel_o,
  output wire logic [7:0]          ctrl_offset_o,
  output wire logic                ctrl_read_o,
  output wire logic                ctrl_write_o
);
  import pcsd_pkg::*;

  // ----------------------------------------------------------------
  // Range hits
  // ----------------------------------------------------------------
  wire logic [15:0] addr;
  wire logic        hit_ctrl;
  wire logic        hit_sram;
  wire logic        hit_rom3;
  wire logic        hit_rom2;
  wire logic        hit_win;
  wire logic [3:0]  page_val;
  wire logic        pick_blk1;
  wire logic        pick_blk0;

  assign addr = bus_i.host_address_group;

  pcsd_range #(.LO(PCSD_CTRL_LO), .HI(PCSD_CTRL_HI)) u_ctrl (
    .addr_i (addr),
    .hit_o  (hit_ctrl)
  );
  pcsd_range #(.LO(PCSD_SRAM_LO), .HI(PCSD_SRAM_HI)) u_sram (
    .addr_i (addr),
    .hit_o  (hit_sram)
  );
  pcsd_range #(.LO(PCSD_ROM3_LO), .HI(PCSD_ROM3_HI)) u_rom3 (
    .addr_i (addr),
    .hit_o  (hit_rom3)
  );
  pcsd_range #(.LO(PCSD_ROM2_LO), .HI(PCSD_ROM2_HI)) u_rom2 (
    .addr_i (addr),
    .hit_o  (hit_rom2)
  );
  // Paged window range, unrouted bits masked inside
  pcsd_range #(.LO(PCSD_WIN_LO), .HI(PCSD_WIN_HI)) u_win (
    .addr_i (addr),
    .hit_o  (hit_win)
  );

  // ----------------------------------------------------------------
  // Window paging
  // ----------------------------------------------------------------
  // Four page bits form one value
  assign page_val = {page_i.page_bit_3, page_i.page_bit_2,
                     page_i.page_bit_1, page_i.page_bit_0};

  // Choice of window block from the paging inputs; one function serves
  // both blocks, so the two selects cannot drift apart when paging changes
  function automatic logic win_pick(input logic       blk1,
                                    input logic       md,
                                    input logic       xl,
                                    input logic [3:0] pv);
    logic pick;
    if (md) begin
      pick = blk1 ? xl : !xl;
    end else begin
      pick = (pv == (blk1 ? PCSD_PAGE_ROM1 : PCSD_PAGE_ROM0));
    end
    return pick;
  endfunction

  // Expansion line overrides page register in that mode
  assign pick_blk1 = win_pick(1'b1, expansion_mode_i, host_expansion_line_i, page_val);
  assign pick_blk0 = win_pick(1'b0, expansion_mode_i, host_expansion_line_i, page_val);

  // ----------------------------------------------------------------
  // Select outputs
  // ----------------------------------------------------------------
  // Ranges are disjoint so selects never overlap
  assign sel_o.ctrl_select   = hit_ctrl;
  assign sel_o.sram_select   = hit_sram;
  assign sel_o.rom_select[3] = hit_rom3;
  assign sel_o.rom_select[2] = hit_rom2;
  // Block one on page one, or expansion line high
  assign sel_o.rom_select[1] = hit_win && pick_blk1;
  // Block zero on page zero, or expansion line low
  assign sel_o.rom_select[0] = hit_win && pick_blk0;

  // ----------------------------------------------------------------
  // Control block access
  // ----------------------------------------------------------------
  // Register offset is the low address byte
  assign ctrl_offset_o = addr[PCSD_OFS_W-1:0];

  // Host E qualifies both reads and writes, read/write line picks direction
  // E is the only timing reference here, so both strobes follow its level
  assign ctrl_read_o  = hit_ctrl && bus_i.rd && bus_i.wr;
  assign ctrl_write_o = hit_ctrl && bus_i.rd && !bus_i.wr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Number of selects raised at once; four bits hold all six selects,
  // and the overlap and quiet checks below all read it
  wire logic [3:0] rom_cnt;
  assign rom_cnt = 4'(sel_o.rom_select[0]) + 4'(sel_o.rom_select[1])
                 + 4'(sel_o.rom_select[2]) + 4'(sel_o.rom_select[3])
                 + 4'(sel_o.ctrl_select) + 4'(sel_o.sram_select);

  a_ctrl_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_o.ctrl_select == (addr[15:8] == 8'h28))
    else $error("control select does not match its range");
  a_sram_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_o.sram_select == (addr[15:11] == 5'b0010_0))
    else $error("sram select does not match its range");
  a_rom3_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_o.rom_select[3] == (addr[15:14] == 2'b11))
    else $error("block three select wrong");
  a_rom2_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_o.rom_select[2] == (addr[15:14] == 2'b10))
    else $error("block two select wrong");
  a_rom1_page: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!expansion_mode_i && addr[15:14] == 2'b01) |->
      (sel_o.rom_select[1] == (page_val == 4'h1)))
    else $error("block one select ignores page");
  a_rom0_page: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!expansion_mode_i && addr[15:14] == 2'b01) |->
      (sel_o.rom_select[0] == (page_val == 4'h0)))
    else $error("block zero select ignores page");
  a_xpan_pick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (expansion_mode_i && addr[15:14] == 2'b01) |->
      (sel_o.rom_select[1] == host_expansion_line_i &&
       sel_o.rom_select[0] == !host_expansion_line_i))
    else $error("expansion line pick wrong");
  a_hostio_free: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (addr[15:12] == 4'h1) |-> (rom_cnt == 4'h0))
    else $error("select raised in host io range");
  a_sel_onehot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rom_cnt <= 4'h1)
    else $error("selects overlap");
  a_no_state: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $stable(addr) && $stable(page_val) && $stable(expansion_mode_i)
      && $stable(host_expansion_line_i) |-> $stable(sel_o))
    else $error("selects changed without an input change");

  // Offset plus base gives back the host address inside the block
  a_ofs_base: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_o.ctrl_select |-> (PCSD_CTRL_LO + {8'h00, ctrl_offset_o}) == addr)
    else $error("control offset does not rebuild the address");
  // Offset spans the whole 256 byte block
  a_ofs_byte: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_offset_o == addr[7:0])
    else $error("control offset is not the low address byte");
  // Outside expansion mode, page values above one open neither window block
  a_page_word: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!expansion_mode_i && addr[15:14] == 2'b01
      && {page_i.page_bit_3, page_i.page_bit_2, page_i.page_bit_1, page_i.page_bit_0} > 4'h1)
      |-> (sel_o.rom_select[1:0] == 2'b00))
    else $error("window opened on a page above one");
  // Address bits 7..2 alone never move a select
  a_mask_bits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $stable(addr[15:8]) && $stable(addr[1:0]) && $stable(page_val)
      && $stable(expansion_mode_i) && $stable(host_expansion_line_i) |-> $stable(sel_o))
    else $error("select followed an unrouted address bit");
  // Strobes only inside the control block, while E is high, never both
  a_ctrl_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ctrl_read_o || ctrl_write_o) |-> (sel_o.ctrl_select && bus_i.rd
      && (ctrl_read_o == bus_i.wr) && (ctrl_write_o == !bus_i.wr)))
    else $error("control strobe outside a qualified cycle");
  // Low space and the gap above the control block stay unselected
  a_gap_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (addr[15:13] == 3'b000 || (addr[15:14] == 2'b00 && addr[13:8] > 6'h28))
      |-> (rom_cnt == 4'h0))
    else $error("select raised outside every mapped range");
  // Upper half always hits exactly one fixed block, any page
  a_upper_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    addr[15] |-> (sel_o.rom_select[3] != sel_o.rom_select[2]) && rom_cnt == 4'h1)
    else $error("upper half not covered by one fixed block");
  // A window hit on page zero or one raises exactly one block
  a_win_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (hit_win && (expansion_mode_i || page_val <= 4'h1)) |-> (rom_cnt == 4'h1))
    else $error("window hit did not raise exactly one block");

  // ----------------------------------------------------------------
  // Per-block quadrant checks
  // ----------------------------------------------------------------
  // Each EPROM block may only answer inside its own 16K quadrant; the
  // two window blocks share quadrant one
  for (genvar gi = 0; gi < PCSD_NUM_ROM; gi++) begin : g_rom_quad
    localparam logic [1:0] QUAD = (gi < 2) ? 2'b01 : 2'(gi);
    a_rom_quad: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sel_o.rom_select[gi] |-> (addr[15:14] == QUAD))
      else $error("EPROM block select outside its quadrant");
  end

endmodule // pcsd_decoder

// >>> rtl/pcsd_pkg.sv
// Package for the paged memory chip select decoder: address map and select layout
package pcsd_pkg;

  // ----------------------------------------------------------------
  // Address map (16-bit host space)
  // ----------------------------------------------------------------
  localparam logic [15:0] PCSD_CTRL_LO   = 16'h2800;
  localparam logic [15:0] PCSD_CTRL_HI   = 16'h28FF;
  localparam logic [15:0] PCSD_SRAM_LO   = 16'h2000;
  localparam logic [15:0] PCSD_SRAM_HI   = 16'h27FF;
  localparam logic [15:0] PCSD_ROM3_LO   = 16'hC000;
  localparam logic [15:0] PCSD_ROM3_HI   = 16'hFFFF;
  localparam logic [15:0] PCSD_ROM2_LO   = 16'h8000;
  localparam logic [15:0] PCSD_ROM2_HI   = 16'hBFFF;
  localparam logic [15:0] PCSD_WIN_LO    = 16'h4000;
  localparam logic [15:0] PCSD_WIN_HI    = 16'h7FFF;
  localparam logic [15:0] PCSD_HOSTIO_LO = 16'h1000;
  localparam logic [15:0] PCSD_HOSTIO_HI = 16'h1FFF;

  // Address lines routed to the decoder: 15..8 and 1..0
  localparam logic [15:0] PCSD_ADDR_USED = 16'hFF03;

  // Page numbers of the two window blocks
  localparam logic [3:0]  PCSD_PAGE_ROM0 = 4'h0;
  localparam logic [3:0]  PCSD_PAGE_ROM1 = 4'h1;

  // Width of the control block register offset
  localparam int          PCSD_OFS_W     = 8;

  // Number of EPROM blocks
  localparam int          PCSD_NUM_ROM   = 4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Host bus cycle as seen at the device pins
  typedef struct packed {
    logic [15:0] host_address_group;
    logic        wr;    // Host read/write line
    logic        rd;    // Host E strobe
  } pcsd_bus_t;

  // Four page register output bits
  typedef struct packed {
    logic page_bit_3;
    logic page_bit_2;
    logic page_bit_1;
    logic page_bit_0;
  } pcsd_page_t;

  // Decoded selects
  typedef struct packed {
    logic                    ctrl_select;
    logic                    sram_select;
    logic [PCSD_NUM_ROM-1:0] rom_select;   // Bit n is rom_blockn_select
  } pcsd_sel_t;

endpackage : pcsd_pkg

// >>> rtl/pcsd_range.sv
// Inclusive address range comparator on the routed address lines
`timescale 1ns/100ps
module pcsd_range #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hFFFF
) (
  // Address in
  input  wire logic [15:0] addr_i,
  // Match out
  output wire logic        hit_o
);
  import pcsd_pkg::*;

  // Unrouted lines forced to don't-care by masking both sides
  wire logic [15:0] addr_m;
  wire logic [15:0] lo_m;
  wire logic [15:0] hi_m;

  // Only routed lines reach the compare
  // Masking keeps the compare exact for ranges aligned on routed bits
  assign addr_m = addr_i & PCSD_ADDR_USED;
  assign lo_m   = LO & PCSD_ADDR_USED;
  assign hi_m   = HI & PCSD_ADDR_USED;
  assign hit_o  = (addr_m >= lo_m) && (addr_m <= hi_m);

endmodule // pcsd_range

// >>> sim/pcsd_host_model.sv
// Host model: non-multiplexed bus controller driving the decoder's bus pins
`timescale 1ns/100ps
module pcsd_host_model (
  // Requests from the bench
  input  wire logic                [15:0] addr_i,
  input  wire logic                       read_i,
  input  wire logic                       strobe_i,
  // Bus pins toward the device
  output wire pcsd_pkg::pcsd_bus_t        bus_o
);
  import pcsd_pkg::*;
  // Read/write into wr, E into rd
  // Address bus is never released, so every line carries a real level
  assign bus_o = {addr_i, read_i, strobe_i};
endmodule // pcsd_host_model

// >>> sim/tb_top.sv
// Self-checking bench for the paged chip select decoder
`timescale 1ns/100ps
module tb_top;
  import pcsd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [15:0] h_addr = 16'h0000;
  logic        h_read = 1'b0;
  logic        h_strobe = 1'b0;
  pcsd_page_t  page = '0;
  logic        exp_line = 1'b0;
  logic        mode = 1'b0;
  pcsd_bus_t   bus;
  pcsd_sel_t   sel;
  logic [7:0]  ofs;
  logic        c_rd;
  logic        c_wr;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          seed = 32'h226f;
  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Cuts a hang; the whole run needs well under 600 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  pcsd_host_model u_pcsd_host_model (.addr_i(h_addr), .read_i(h_read), .strobe_i(h_strobe),
                                     .bus_o(bus));
  pcsd_decoder u_pcsd_decoder (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .page_i(page),
    .host_expansion_line_i(exp_line), .expansion_mode_i(mode), .sel_o(sel),
    .ctrl_offset_o(ofs), .ctrl_read_o(c_rd), .ctrl_write_o(c_wr));
  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic pcsd_sel_t exp_sel(logic [15:0] a, logic [3:0] pg, logic xl, logic md);
    pcsd_sel_t s;
    logic      win;
    win = a >= PCSD_WIN_LO && a <= PCSD_WIN_HI;
    s.ctrl_select = a >= PCSD_CTRL_LO && a <= PCSD_CTRL_HI;
    s.sram_select = a >= PCSD_SRAM_LO && a <= PCSD_SRAM_HI;
    s.rom_select[3] = a >= PCSD_ROM3_LO;
    s.rom_select[2] = a >= PCSD_ROM2_LO && a <= PCSD_ROM2_HI;
    s.rom_select[1] = win && (md ? xl : pg == PCSD_PAGE_ROM1);
    s.rom_select[0] = win && (md ? !xl : pg == PCSD_PAGE_ROM0);
    return s;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  // Drives one bus cycle at the falling edge, checks at the rising edge
  task automatic apply(input logic [15:0] a, input logic [3:0] pg, input logic xl, md);
    int r;
    pcsd_sel_t s;
    r = $random(seed);
    @(negedge clk_i);
    h_addr <= a;
    h_read <= r[0];
    h_strobe <= r[1];
    page <= pg;
    exp_line <= xl;
    mode <= md;
    @(posedge clk_i);
    s = exp_sel(a, pg, xl, md);
    check({12'h000, sel.rom_select}, {12'h000, s.rom_select});
    check({12'h000, sel.rom_select}, {12'h000, s.rom_select});
    check({14'h0000, sel.ctrl_select, sel.sram_select},
          {14'h0000, s.ctrl_select, s.sram_select});
    check({8'h00, ofs}, {8'h00, a[7:0]});
    check({14'h0000, c_rd, c_wr}, {14'h0000, s.ctrl_select & r[1] & r[0],
          s.ctrl_select & r[1] & !r[0]});
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    static logic [15:0] edges [17] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h27FF,
      16'h2800, 16'h28FF, 16'h2900, 16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'hBFFF,
      16'hC000, 16'hFFFF, 16'h28A7};
    int r;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // Range boundaries, host I/O hole included
    foreach (edges[i]) apply(edges[i], 4'h0, 1'b0, 1'b0);
    // Bits 7..2 walk inside the control block, selects hold still
    for (int k = 0; k < 8; k++) apply({8'h28, 6'(k * 9), 2'b01}, 4'h0, 1'b0, 1'b0);
    // Every page value at both window ends
    for (int p = 0; p < 16; p++) begin
      apply(16'h4000, p[3:0], 1'b1, 1'b0);
      apply(16'h7FFF, p[3:0], 1'b0, 1'b0);
    end
    // Expansion line paging ignores the page bits
    for (int k = 0; k < 4; k++) apply(16'h5A5A, 4'h1 - k[0], k[0], 1'b1);
    // Random traffic; bits 7..2 vary freely
    repeat (400) begin
      r = $random(seed);
      apply(r[31:16], r[3:0], r[4], r[5]);
    end
    wrap_up();
  end
endmodule // tb_top
